//--- design/cwd_pkg.sv
// package: register map, fields and reset values of the countdown watchdog
package cwd_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_RELOAD = 12'h000;
  localparam logic [11:0] OFS_READBACK = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_ICLR = 12'h00C;
  localparam logic [11:0] OFS_RAW = 12'h010;
  localparam logic [11:0] OFS_MASKED = 12'h014;
  localparam logic [11:0] OFS_EVT_STAT = 12'h018;
  localparam logic [11:0] OFS_EVT_MASK = 12'h01C;
  localparam logic [11:0] OFS_GUARD = 12'hC00;
  // ==========================================
  // field positions
  localparam int BIT_IRQ_GEN = 0;
  localparam int BIT_REBOOT = 1;
  localparam int BIT_EVT_ZERO = 0;
  localparam int BIT_EVT_RST = 1;
  localparam int EVT_W = 2;
  // ==========================================
  // reset values and the unlock key
  localparam logic [31:0] RST_RELOAD = 32'hFFFFFFFF;
  localparam logic [31:0] RST_COUNT = 32'hFFFFFFFF;
  localparam logic [31:0] GUARD_KEY = 32'h1ACCE551;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  // ==========================================
  // timing
  localparam int SLOW_HZ = 32768;
  localparam int HCLK_HZ = 100000000;
  localparam int SYNC_STAGES = 2;
  // ==========================================
  // control register fields
  typedef struct packed {
    logic reboot_on_overrun;
    logic irq_gen_on;
  } cwd_ctrl_t;
  // latched address phase of a bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] ofs;
  } cwd_aphase_t;
endpackage

//--- design/cwd_top.sv
// module: countdown watchdog with AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
module cwd_top #(
  parameter int CNT_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic slow_clk,
  output logic irq,
  output logic wdog_reset_req
);

  // ==========================================
  // elaboration check
  if (CNT_W != 32)
  begin : g_bad_width
    $error("cwd_top supports CNT_W of 32 only");
  end

  // ==========================================
  // state
  localparam int SYNC_STAGES_L = cwd_pkg::SYNC_STAGES;
  logic [SYNC_STAGES_L-1:0] slow_sync_q; // synchroniser chain
  logic slow_prev_q; // last synchronised level
  logic tick; // one-cycle pulse per slow rising edge
  logic [31:0] reload_store_q; // reload value
  logic [31:0] live_count_q; // running count
  cwd_pkg::cwd_ctrl_t ctrl_q; // control bits
  logic raw_q; // raw interrupt status
  logic locked_q; // write guard state
  logic rst_req_q; // reset request
  logic [cwd_pkg::EVT_W-1:0] evt_stat_q; // sticky events
  logic [cwd_pkg::EVT_W-1:0] evt_mask_q; // event mask
  logic irq_q; // interrupt output flop
  cwd_pkg::cwd_aphase_t aph_q; // latched address phase
  logic [31:0] rdata_q; // read data flop

  // ==========================================
  // bus decode
  logic addr_take; // address phase accepted
  logic wr_ok; // data-phase write allowed
  logic wr_reload; // write to reload register
  logic wr_ctrl; // write to control register
  logic wr_iclr; // write to clear port
  logic wr_guard; // write to guard register
  logic wr_estat; // write to event status
  logic wr_emask; // write to event mask
  logic zero_hit; // counter hits zero this tick
  logic overrun; // zero while status still set
  logic gen_rise; // irq generation being switched on
  logic [cwd_pkg::EVT_W-1:0] evt_set; // event set pulses

  // accept any NONSEQ or SEQ when selected and bus ready
  assign addr_take = hsel && hready && htrans[1];
  // writes pass only while unlocked
  assign wr_ok = aph_q.valid && aph_q.write && !locked_q;
  assign wr_reload = wr_ok && (aph_q.ofs == cwd_pkg::OFS_RELOAD);
  assign wr_ctrl = wr_ok && (aph_q.ofs == cwd_pkg::OFS_CONTROL);
  assign wr_iclr = wr_ok && (aph_q.ofs == cwd_pkg::OFS_ICLR);
  assign wr_estat = wr_ok && (aph_q.ofs == cwd_pkg::OFS_EVT_STAT);
  assign wr_emask = wr_ok && (aph_q.ofs == cwd_pkg::OFS_EVT_MASK);
  // guard itself is always writable
  assign wr_guard = aph_q.valid && aph_q.write
    && (aph_q.ofs == cwd_pkg::OFS_GUARD);
  // enable bit going from zero to one
  assign gen_rise = wr_ctrl && hwdata[cwd_pkg::BIT_IRQ_GEN]
    && !ctrl_q.irq_gen_on;

  // ==========================================
  // slow clock synchroniser
  // two flops, then edge detect on the settled stage only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slow_sync_q <= '0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      slow_sync_q <= {slow_sync_q[SYNC_STAGES_L-2:0], slow_clk};
      slow_prev_q <= slow_sync_q[SYNC_STAGES_L-1];
    end
  end

  // rising edge of the synchronised slow clock
  assign tick = slow_sync_q[SYNC_STAGES_L-1] && !slow_prev_q;
  // zero reached on a counting tick
  assign zero_hit = tick && ctrl_q.irq_gen_on
    && (live_count_q == cwd_pkg::ZERO_WORD);
  // second zero before the first was cleared
  assign overrun = zero_hit && raw_q;

  // ==========================================
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_q <= '0;
    end
    else if (hready)
    begin
      // new address phase or idle
      aph_q.valid <= addr_take;
      aph_q.write <= hwrite;
      aph_q.ofs <= haddr[11:0];
    end
  end

  // ==========================================
  // reload register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reload_store_q <= cwd_pkg::RST_RELOAD;
    end
    else if (wr_reload)
    begin
      reload_store_q <= hwdata;
    end
  end

  // ==========================================
  // down counter
  // priority: reload write, clear, enable, zero, decrement
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      live_count_q <= cwd_pkg::RST_COUNT;
    end
    else if (wr_reload)
    begin
      // restart from the new value at once
      live_count_q <= hwdata;
    end
    else if (wr_iclr)
    begin
      // clearing the interrupt reloads too
      live_count_q <= reload_store_q;
    end
    else if (gen_rise)
    begin
      // fresh start, not the old count
      live_count_q <= reload_store_q;
    end
    else if (zero_hit)
    begin
      // reload after zero gives reload+1 ticks per period
      live_count_q <= reload_store_q;
    end
    else if (tick && ctrl_q.irq_gen_on)
    begin
      // one step per slow tick; holds while disabled
      live_count_q <= live_count_q - 32'h00000001;
    end
  end

  // ==========================================
  // control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= '0;
    end
    else if (wr_ctrl)
    begin
      ctrl_q.irq_gen_on <= hwdata[cwd_pkg::BIT_IRQ_GEN];
      ctrl_q.reboot_on_overrun <= hwdata[cwd_pkg::BIT_REBOOT];
    end
  end

  // ==========================================
  // raw interrupt status
  // a zero in the same cycle as a clear wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      raw_q <= 1'b0;
    end
    else if (zero_hit)
    begin
      raw_q <= 1'b1;
    end
    else if (wr_iclr)
    begin
      raw_q <= 1'b0;
    end
  end

  // ==========================================
  // reset request
  // sticky until the system reset it causes clears it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_req_q <= 1'b0;
    end
    else if (overrun && ctrl_q.reboot_on_overrun)
    begin
      rst_req_q <= 1'b1;
    end
  end

  // ==========================================
  // write guard
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      locked_q <= 1'b0;
    end
    else if (wr_guard)
    begin
      // only the key opens; anything else closes
      locked_q <= (hwdata != cwd_pkg::GUARD_KEY);
    end
  end

  // ==========================================
  // event status and mask
  // one driver for the whole vector: bit1 reset requested, bit0 zero reached
  assign evt_set = {overrun && ctrl_q.reboot_on_overrun, zero_hit};

  // sticky bits, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_stat_q <= '0;
    end
    else
    begin
      if (wr_estat)
      begin
        evt_stat_q <= (evt_stat_q & ~hwdata[cwd_pkg::EVT_W-1:0])
          | evt_set;
      end
      else
      begin
        evt_stat_q <= evt_stat_q | evt_set;
      end
    end
  end

  // mask register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_mask_q <= '0;
    end
    else if (wr_emask)
    begin
      evt_mask_q <= hwdata[cwd_pkg::EVT_W-1:0];
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(evt_stat_q & evt_mask_q);
    end
  end

  // ==========================================
  // read data
  // sampled at the address edge, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= '0;
    end
    else if (addr_take && !hwrite)
    begin
      case (haddr[11:0])
        cwd_pkg::OFS_RELOAD:
        begin
          rdata_q <= reload_store_q;
        end
        cwd_pkg::OFS_READBACK:
        begin
          rdata_q <= live_count_q;
        end
        cwd_pkg::OFS_CONTROL:
        begin
          rdata_q <= {30'h0, ctrl_q.reboot_on_overrun, ctrl_q.irq_gen_on};
        end
        cwd_pkg::OFS_ICLR:
        begin
          rdata_q <= cwd_pkg::ZERO_WORD;
        end
        cwd_pkg::OFS_RAW:
        begin
          rdata_q <= {31'h0, raw_q};
        end
        cwd_pkg::OFS_MASKED:
        begin
          rdata_q <= {31'h0, raw_q && ctrl_q.irq_gen_on};
        end
        cwd_pkg::OFS_EVT_STAT:
        begin
          rdata_q <= {30'h0, evt_stat_q};
        end
        cwd_pkg::OFS_EVT_MASK:
        begin
          rdata_q <= {30'h0, evt_mask_q};
        end
        cwd_pkg::OFS_GUARD:
        begin
          rdata_q <= {31'h0, locked_q};
        end
        default:
        begin
          // unmapped reads as zero
          rdata_q <= cwd_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  // ==========================================
  // outputs, all from flops
  // zero wait states and OKAY always
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_q;
  assign irq = irq_q;
  assign wdog_reset_req = rst_req_q;

endmodule

//--- tb/cwd_properties.sv
// checker: bus answer and reset request properties of the countdown watchdog
module cwd_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic wdog_reset_req
);
  // ========================================
  // read address phase taken at this edge
  logic rd;
  // decoded part of the address
  logic [11:0] ofs;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign ofs = haddr[11:0];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay:
    assert property (hresp == 1'b0) else $error("error response seen");
  a_ready_up:
    assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
  a_rdata_hold:
    assert property (!$past(rd) |-> $stable(hrdata)) else $error("read data moved");
  a_clear_reads:
    assert property (rd && ofs == 12'h00C |=> hrdata == 32'h00000000) else $error("clear port");
  a_status_field:
    assert property (rd && (ofs == 12'h010 || ofs == 12'h014) |=> hrdata[31:1] == 31'h0)
    else $error("status field");
  a_guard_field:
    assert property (rd && ofs == 12'hC00 |=> hrdata[31:1] == 31'h0) else $error("guard field");
  a_ctrl_field:
    assert property (rd && ofs == 12'h008 |=> hrdata[31:2] == 30'h0) else $error("control field");
  a_unmapped_zero:
    assert property (rd && ofs == 12'h100 |=> hrdata == 32'h00000000) else $error("unmapped read");
  a_req_sticky:
    assert property (wdog_reset_req |=> wdog_reset_req) else $error("reset request dropped");
endmodule

bind cwd_top cwd_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .wdog_reset_req(wdog_reset_req));

//--- tb/cwd_top_tb.sv
// testbench: register, countdown, interrupt and reset request tests of the watchdog
module cwd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // stimulus, all set at time zero
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic slow_clk = 1'b0;
  // design answers; hready is the one slave's hreadyout
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic irq;
  wire logic wdog_reset_req;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  // registers that come out of reset as zero
  logic [11:0] zr [7] = '{cwd_pkg::OFS_CONTROL, cwd_pkg::OFS_ICLR, cwd_pkg::OFS_RAW,
    cwd_pkg::OFS_MASKED, cwd_pkg::OFS_GUARD, cwd_pkg::OFS_EVT_STAT, cwd_pkg::OFS_EVT_MASK};
  always #5 hclk = ~hclk;
  cwd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .slow_clk(slow_clk), .irq(irq),
    .wdog_reset_req(wdog_reset_req));
  // ========================================
  // closing report, reached from the main sequence or the timeout
  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  // one compare for every word result
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // single transfer: address phase, then data phase, each held until hready
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  // read and compare
  task rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h00000000, r);
    chk(r, e);
  endtask
  // slow clock pulses, high and low four bus cycles each; idle low between
  task tick(input int n);
    repeat (n)
    begin
      slow_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      slow_clk <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
  // reset held two cycles, first transfer two edges after release
  task do_reset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  // ========================================
  // reset values, unmapped read
  task t_reset();
    rc(cwd_pkg::OFS_RELOAD, cwd_pkg::RST_RELOAD);
    rc(cwd_pkg::OFS_READBACK, cwd_pkg::RST_COUNT);
    foreach (zr[i]) rc(zr[i], cwd_pkg::ZERO_WORD);
    chk({30'h0, irq, wdog_reset_req}, cwd_pkg::ZERO_WORD);
    rc(12'h100, cwd_pkg::ZERO_WORD);
    $display("reset test done");
  endtask
  // lock blocks writes, key opens them
  task t_guard();
    wr(cwd_pkg::OFS_GUARD, 32'h00000001);
    rc(cwd_pkg::OFS_GUARD, 32'h00000001);
    wr(cwd_pkg::OFS_RELOAD, 32'h00000007);
    rc(cwd_pkg::OFS_RELOAD, cwd_pkg::RST_RELOAD);
    wr(cwd_pkg::OFS_GUARD, cwd_pkg::GUARD_KEY);
    rc(cwd_pkg::OFS_GUARD, 32'h00000000);
    wr(cwd_pkg::OFS_RELOAD, 32'h00000007);
    rc(cwd_pkg::OFS_READBACK, 32'h00000007);
    wr(cwd_pkg::OFS_READBACK, 32'h00000055);
    wr(cwd_pkg::OFS_RAW, 32'h00000001);
    tick(2);
    rc(cwd_pkg::OFS_READBACK, 32'h00000007);
    rc(cwd_pkg::OFS_RAW, 32'h00000000);
    $display("guard test done");
  endtask
  // countdown, restart on enable, zero event, interrupt, clear port
  task t_count();
    wr(cwd_pkg::OFS_RELOAD, 32'h00000002);
    wr(cwd_pkg::OFS_CONTROL, 32'h00000001);
    tick(1);
    rc(cwd_pkg::OFS_READBACK, 32'h00000001);
    wr(cwd_pkg::OFS_CONTROL, 32'h00000000);
    wr(cwd_pkg::OFS_CONTROL, 32'h00000001);
    rc(cwd_pkg::OFS_READBACK, 32'h00000002);
    tick(2);
    rc(cwd_pkg::OFS_RAW, 32'h00000000);
    tick(1);
    rc(cwd_pkg::OFS_RAW, 32'h00000001);
    rc(cwd_pkg::OFS_READBACK, 32'h00000002);
    rc(cwd_pkg::OFS_MASKED, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    wr(cwd_pkg::OFS_EVT_MASK, 32'h00000001);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000001);
    wr(cwd_pkg::OFS_EVT_STAT, 32'h00000001);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000000);
    tick(1);
    wr(cwd_pkg::OFS_ICLR, 32'h000000A5);
    rc(cwd_pkg::OFS_RAW, 32'h00000000);
    rc(cwd_pkg::OFS_READBACK, 32'h00000002);
    $display("count test done");
  endtask
  // second zero with status set: no request unless enabled, then sticky until reset
  task t_reboot();
    tick(6);
    chk({31'h0, wdog_reset_req}, 32'h00000000);
    wr(cwd_pkg::OFS_CONTROL, 32'h00000000);
    rc(cwd_pkg::OFS_MASKED, 32'h00000000);
    wr(cwd_pkg::OFS_CONTROL, 32'h00000003);
    rc(cwd_pkg::OFS_CONTROL, 32'h00000003);
    tick(3);
    chk({31'h0, wdog_reset_req}, 32'h00000001);
    rc(cwd_pkg::OFS_EVT_STAT, 32'h00000003);
    do_reset();
    chk({31'h0, wdog_reset_req}, 32'h00000000);
    $display("reboot test done");
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_guard();
    t_count();
    t_reboot();
    wrap_up();
  end
endmodule
